// ### src/servo_axis_pid_profile.sv
// Notes on behaviour
// - filter recomputes the drive on a periodic tick, 2048 times a second
// - drive = err*P + (err - previous err)*D + accumulated err*I
// - after each computation add err to accumulator, keep err as previous; the code clears the accumulator instead while correction is inactive
// - result scaled onto signed command span of +-10 V, sign gives direction
// - error is actual position minus commanded position in encoder counts
// - default filter after start-up; other filter chosen only before first profile
// - proportional gain 1 to 255 multiplies the position error
// - integral gain 0 to 255 weights the accumulated error
// - derivative gain 0 to 255 weights the change in error per tick
// - hold mode keeps correcting toward target after arrival
// - deadband mode corrects only while absolute error exceeds deadband; the code corrects regardless of the deadband while moving
// - off mode stops all correction once the target is reached
// - profile must precede first move; move on unprofiled axis raises not-ready
// - new profile applies at once; fields not given keep earlier values; the first profile loads all fields
// - deceleration defaults to the acceleration unless set separately
// - speed in steps/s and acceleration in steps/s^2, one-unit resolution
// - a new acceleration overwrites a separately set deceleration
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "servo_axis_defs.svh"

module servo_axis_pid_profile
   import servo_axis_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned SCALE_SHIFT = 0
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic signed [31:0] enc_pos_i,
   output logic signed [15:0] drive_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   state_t s;
   state_t n;
   logic tick;
   logic acc_en;
   logic [31:0] lane_m;
   logic [31:0] wm;
   logic [3:0] use_f;
   logic [2:0] irq_set;
   logic signed [31:0] cmd_int;
   logic signed [32:0] err_now;
   logic signed [32:0] rem_s;
   logic [32:0] rmag;
   logic [32:0] emag;
   logic signed [57:0] sum;
   logic signed [57:0] scaled;
   logic active;
   logic wrong;
   logic need_dec;
   logic [35:0] vmax;
   logic [35:0] vup;
   logic [71:0] vsq;
   logic [56:0] dprod;

   for (genvar b = 0; b < 4; b++)
   begin : g_lane
      assign lane_m[8*b +: 8] = {8{wb_sel_i[b]}};
   end

   assign wm = wb_dat_i & lane_m;
   assign cmd_int = s.pos_fx[53:`POS_FRAC];
   assign err_now = 33'(enc_pos_i) - 33'(cmd_int);
   assign rem_s = 33'(s.target) - 33'(cmd_int);
   assign rmag = rem_s[32] ? 33'(-rem_s) : 33'(rem_s);
   assign emag = err_now[32] ? 33'(-err_now) : 33'(err_now);
   // stopping distance v^2/(2a) in fixed point: vel^2 >= decel*rem*2^23
   assign vsq = 72'(s.vel) * 72'(s.vel);
   assign dprod = 57'(s.decel) * 57'(rmag);
   assign vmax = {1'b0, s.maxspd, 11'h000};
   assign vup = s.vel + 36'(s.accel);

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      n = s;
      n.ack = 1'b0;
      irq_set = 3'h0;
      use_f = s.profiled ? wm[`CMD_USE_LSB +: 4] : 4'hF;
      tick = (s.tick_cnt == `CNT_W'(TICK_CYCLES - 1));
      n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
      wrong = 1'b0;
      need_dec = 1'b0;
      active = 1'b0;
      sum = '0;
      scaled = '0;

      // bus slave
      acc_en = wb_cyc_i & wb_stb_i & ~s.ack;
      if (acc_en)
      begin
         n.ack = 1'b1;
         n.rdat = 32'h0000_0000;
         if (wb_we_i)
         begin
            case (wb_adr_i)
               `REG_CMD:
               begin
                  if (wm[`CMD_PROFILE])
                  begin
                     if (use_f[0])
                        n.maxspd = s.maxspd_stg;
                     if (use_f[1])
                     begin
                        n.accel = s.accel_stg;
                        n.decel = s.accel_stg;
                     end
                     if (use_f[2])
                     begin
                        n.kp = (s.gains_stg[`GAIN_P_LSB +: 8] == 8'h00) ? `P_GAIN_MIN
                               : s.gains_stg[`GAIN_P_LSB +: 8];
                        n.ki = s.gains_stg[`GAIN_I_LSB +: 8];
                        n.kd = s.gains_stg[`GAIN_D_LSB +: 8];
                     end
                     if (use_f[3])
                        n.hold = hold_mode_t'(s.gains_stg[`GAIN_HOLD_LSB +: 2]);
                     n.profiled = 1'b1;
                  end
                  if (wm[`CMD_MOVE])
                  begin
                     if (!n.profiled)
                        irq_set[`IRQ_NOT_READY] = 1'b1;
                     else
                        n.mstate = ST_MOVING;
                  end
                  if (wm[`CMD_STOP] && n.profiled)
                  begin
                     n.vel = '0;
                     n.target = cmd_int;
                     n.mstate = ST_HOLDING;
                  end
               end
               `REG_MAXSPD:
                  n.maxspd_stg = (s.maxspd_stg & ~lane_m[23:0]) | wm[23:0];
               `REG_ACCEL:
                  n.accel_stg = (s.accel_stg & ~lane_m[23:0]) | wm[23:0];
               `REG_DECEL:
                  n.decel = (s.decel & ~lane_m[23:0]) | wm[23:0];
               `REG_GAINS:
                  n.gains_stg = (s.gains_stg & ~lane_m[25:0]) | wm[25:0];
               `REG_DEADBAND:
                  n.deadband = (s.deadband & ~lane_m[15:0]) | wm[15:0];
               `REG_FILTER:
               begin
                  if (!s.profiled)
                     n.filter = (s.filter & ~lane_m[2:0]) | wm[2:0];
               end
               `REG_TARGET:
                  n.target = (s.target & ~lane_m) | wm;
               `REG_IRQ_STAT:
                  n.irq_stat = s.irq_stat & ~wm[2:0];
               `REG_IRQ_MASK:
                  n.irq_mask = (s.irq_mask & ~lane_m[2:0]) | wm[2:0];
               default:
               begin
               end
            endcase
         end
         else
         begin
            case (wb_adr_i)
               `REG_MAXSPD: n.rdat = {8'h00, s.maxspd_stg};
               `REG_ACCEL: n.rdat = {8'h00, s.accel_stg};
               `REG_DECEL: n.rdat = {8'h00, s.decel};
               `REG_GAINS: n.rdat = {6'h00, s.gains_stg};
               `REG_DEADBAND: n.rdat = {16'h0000, s.deadband};
               `REG_FILTER: n.rdat = {29'h0, s.filter};
               `REG_TARGET: n.rdat = s.target;
               `REG_POS: n.rdat = enc_pos_i;
               `REG_ERR: n.rdat = s.err[31:0];
               `REG_DRIVE: n.rdat = 32'(s.drive);
               `REG_STATUS: n.rdat = {28'h0, s.hold == HOLD_OFF, s.mstate == ST_HOLDING,
                                      s.mstate == ST_MOVING, s.profiled};
               `REG_IRQ_STAT: n.rdat = {29'h0, s.irq_stat};
               `REG_IRQ_MASK: n.rdat = {29'h0, s.irq_mask};
               default: n.rdat = 32'h0000_0000;
            endcase
         end
      end

      // filter and trajectory, once per tick
      if (tick && s.profiled)
      begin
         case (s.hold)
            HOLD_SERVO: active = 1'b1;
            HOLD_DEADBAND: active = (emag > 33'(s.deadband));
            HOLD_OFF: active = 1'b0;
            default: active = 1'b0;
         endcase
         if (s.mstate == ST_MOVING)
            active = 1'b1;
         if (s.filter != `FILTER_PID)
            active = 1'b0;
         sum = 58'(err_now) * 58'($signed({1'b0, s.kp}))
             + 58'(err_now - s.prev_err) * 58'($signed({1'b0, s.kd}))
             + 58'(s.acc) * 58'($signed({1'b0, s.ki}));
         scaled = sum >>> SCALE_SHIFT;
         n.err = err_now;
         if (active)
         begin
            if (scaled > 58'sd32767)
            begin
               n.drive = `DRV_MAX;
               irq_set[`IRQ_SATURATED] = 1'b1;
            end
            else if (scaled < -58'sd32767)
            begin
               n.drive = `DRV_MIN;
               irq_set[`IRQ_SATURATED] = 1'b1;
            end
            else
               n.drive = scaled[15:0];
            n.acc = s.acc + 48'(err_now);
            n.prev_err = err_now;
         end
         else
         begin
            n.drive = '0;
            n.acc = '0;
            n.prev_err = err_now;
         end

         if (s.mstate == ST_MOVING)
         begin
            if (s.vel == '0)
               n.dir_neg = rem_s[32];
            wrong = (rmag != '0) && (rem_s[32] != s.dir_neg) && (s.vel != '0);
            need_dec = wrong || ({8'h00, vsq} >= {dprod, 23'h0});
            if (need_dec)
               n.vel = (s.vel > 36'(s.decel)) ? s.vel - 36'(s.decel) : '0;
            else
               n.vel = (vup > vmax) ? vmax : vup;
            if (({19'h0, n.vel} >= {rmag, 22'h0}) || (n.vel == '0 && !wrong))
            begin
               n.pos_fx = {s.target, 22'h0};
               n.vel = '0;
               n.mstate = ST_HOLDING;
               irq_set[`IRQ_ARRIVED] = 1'b1;
            end
            else if (n.dir_neg)
               n.pos_fx = s.pos_fx - $signed(54'(n.vel));
            else
               n.pos_fx = s.pos_fx + $signed(54'(n.vel));
         end
      end

      n.irq_stat = n.irq_stat | irq_set;
      n.irq = |(n.irq_stat & n.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s <= '0;
      else
         s <= n;
   end

   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign drive_o = s.drive;
   assign irq_o = s.irq;

endmodule // servo_axis_pid_profile

`default_nettype wire

// ### src/servo_axis_defs.svh
`ifndef SERVO_AXIS_DEFS_SVH
`define SERVO_AXIS_DEFS_SVH

// register byte offsets
`define REG_CMD 8'h00
`define REG_MAXSPD 8'h04
`define REG_ACCEL 8'h08
`define REG_DECEL 8'h0C
`define REG_GAINS 8'h10
`define REG_DEADBAND 8'h14
`define REG_FILTER 8'h18
`define REG_TARGET 8'h1C
`define REG_POS 8'h20
`define REG_ERR 8'h24
`define REG_DRIVE 8'h28
`define REG_STATUS 8'h2C
`define REG_IRQ_STAT 8'h30
`define REG_IRQ_MASK 8'h34

// command register bits
`define CMD_PROFILE 0
`define CMD_MOVE 1
`define CMD_STOP 2
`define CMD_USE_LSB 4

// gains register fields
`define GAIN_P_LSB 0
`define GAIN_I_LSB 8
`define GAIN_D_LSB 16
`define GAIN_HOLD_LSB 24

// interrupt status bits
`define IRQ_NOT_READY 0
`define IRQ_ARRIVED 1
`define IRQ_SATURATED 2

// timing
`define CLK_HZ 200000000
`define TICK_HZ 2048
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define CNT_W 17
`define VEL_FRAC 11
`define POS_FRAC 22

`define P_GAIN_MIN 8'h01
`define FILTER_PID 3'h0
`define DRV_MAX 16'h7FFF
`define DRV_MIN 16'h8001

`endif

// ### src/servo_axis_pkg.sv
`default_nettype none
package servo_axis_pkg;

   typedef enum logic [1:0] {HOLD_SERVO, HOLD_DEADBAND, HOLD_OFF} hold_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_MOVING, ST_HOLDING} motion_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic [16:0] tick_cnt;
      logic [23:0] maxspd_stg;
      logic [23:0] accel_stg;
      logic [25:0] gains_stg;
      logic [23:0] maxspd;
      logic [23:0] accel;
      logic [23:0] decel;
      logic [7:0] kp;
      logic [7:0] ki;
      logic [7:0] kd;
      hold_mode_t hold;
      logic [15:0] deadband;
      logic [2:0] filter;
      logic profiled;
      logic signed [31:0] target;
      motion_t mstate;
      logic dir_neg;
      logic [35:0] vel;
      logic signed [53:0] pos_fx;
      logic signed [32:0] err;
      logic signed [32:0] prev_err;
      logic signed [47:0] acc;
      logic signed [15:0] drive;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
   } state_t;

endpackage

`default_nettype wire

// ### test/servo_axis_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module servo_axis_chk (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic signed [15:0] drive_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   chk_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
      else $error("ack without request");
   chk_rdat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved without ack");
   chk_drive_span: assert property (drive_o != 16'h8000)
      else $error("drive outside symmetric span");
   chk_drive_steady: assert property ($changed(drive_o) |=> $stable(drive_o)[*8])
      else $error("drive changed between ticks");
   chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h40
      |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   chk_cmd_rdzero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h00
      |=> wb_dat_o == 32'h0) else $error("command read not zero");
endmodule // servo_axis_chk
bind servo_axis_pid_profile servo_axis_chk u_chk (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .drive_o);
`default_nettype wire

// ### test/servo_amp_model.sv
`timescale 1ns/1ps
`default_nettype none
module servo_amp_model (
   input wire logic clk_sys_i,
   input wire logic signed [15:0] drive_i,
   input wire logic follow_i,
   input wire logic signed [31:0] force_i,
   output logic signed [31:0] enc_pos_o
);
   logic signed [31:0] moved_q;
   // positive drive pulls the shaft back toward lower counts
   always_ff @(posedge clk_sys_i)
   begin
      if (!follow_i)
         moved_q <= 32'sh0;
      else if (drive_i > 0)
         moved_q <= moved_q - 32'sh1;
      else if (drive_i < 0)
         moved_q <= moved_q + 32'sh1;
   end
   assign enc_pos_o = force_i + moved_q;
endmodule // servo_amp_model
`default_nettype wire

// ### test/servo_axis_pid_profile_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_axis_defs.svh"
module servo_axis_pid_profile_tb;
   logic clk_sys_i, rst_n_i, cyc, stb, we, follow, wb_ack_o, irq_o;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, wb_dat_o;
   logic signed [31:0] force_pos, enc_pos;
   logic signed [15:0] drive_o;
   int cnt, bad_count, n_checks;
   servo_axis_pid_profile #(.TICK_CYCLES(64), .SCALE_SHIFT(0)) u_dut (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_pos_i(enc_pos), .drive_o(drive_o),
      .irq_o(irq_o));
   servo_amp_model u_amp (.clk_sys_i(clk_sys_i), .drive_i(drive_o), .follow_i(follow), .force_i(force_pos),
      .enc_pos_o(enc_pos));
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] m, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= m;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
         bad_count++;
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, 4'hF, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 4'hF, 32'h0, q);
      chk(q, e);
   endtask
   // returns 9 cycles after the drive update, well clear of it
   task automatic tick();
      do @(posedge clk_sys_i); while (cnt % 64 != 8);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({16'h0, drive_o}, 32'h0);
      rd(`REG_GAINS, 32'h0);
      rd(`REG_FILTER, 32'h0);
      rd(8'h40, 32'h0);
      rd(`REG_CMD, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_not_ready();
      wr(`REG_IRQ_MASK, 32'h1);
      wr(`REG_CMD, 32'h2);
      chk({31'h0, irq_o}, 32'h1);
      rd(`REG_IRQ_STAT, 32'h1);
      rd(`REG_STATUS, 32'h0);
      wr(`REG_IRQ_STAT, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      $display("not-ready test done");
   endtask
   task automatic t_pid();
      wr(`REG_GAINS, 32'h00030102);
      wr(`REG_CMD, 32'h3);
      wr(`REG_FILTER, 32'h5);
      rd(`REG_FILTER, 32'h0);
      tick();
      force_pos <= 32'sd10;
      tick();
      chk({16'h0, drive_o}, 32'h32);
      rd(`REG_ERR, 32'hA);
      tick();
      chk({16'h0, drive_o}, 32'h1E);
      tick();
      chk({16'h0, drive_o}, 32'h28);
      $display("pid test done");
   endtask
   task automatic t_sat();
      wr(`REG_IRQ_MASK, 32'h4);
      force_pos <= -32'sd200000;
      tick();
      tick();
      chk({16'h0, drive_o}, 32'h8001);
      chk({31'h0, irq_o}, 32'h1);
      wr(`REG_IRQ_MASK, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      $display("saturation test done");
   endtask
   task automatic t_modes();
      wr(`REG_DEADBAND, 32'h14);
      wr(`REG_GAINS, 32'h01000004);
      wr(`REG_CMD, 32'hC1);
      force_pos <= 32'sd20;
      tick();
      tick();
      chk({16'h0, drive_o}, 32'h0);
      force_pos <= 32'sd21;
      tick();
      chk({16'h0, drive_o}, 32'h54);
      wr(`REG_GAINS, 32'h02000004);
      wr(`REG_CMD, 32'hC1);
      force_pos <= 32'sd50;
      tick();
      tick();
      chk({16'h0, drive_o}, 32'h0);
      wr(`REG_GAINS, 32'h00000004);
      wr(`REG_CMD, 32'hC1);
      force_pos <= 32'sd40;
      tick();
      tick();
      chk({16'h0, drive_o}, 32'hA0);
      follow <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      chk({31'h0, enc_pos < 32'sd40}, 32'h1);
      // shaft pushed 14 counts below target by the next tick
      tick();
      chk({16'h0, drive_o}, 32'h0000FFC8);
      follow <= 1'b0;
      $display("holding mode test done");
   endtask
   task automatic t_ramp();
      logic [31:0] q;
      wr(`REG_DECEL, 32'h5);
      rd(`REG_DECEL, 32'h5);
      wr(`REG_ACCEL, 32'h7);
      wr(`REG_CMD, 32'h21);
      rd(`REG_DECEL, 32'h7);
      rd(`REG_ACCEL, 32'h7);
      // only byte lane 1 of the deadband may change
      bus(`REG_DEADBAND, 1'b1, 4'h2, 32'h0000ABCD, q);
      rd(`REG_DEADBAND, 32'h0000AB14);
      $display("ramp test done");
   endtask
   task automatic t_move();
      logic [31:0] q;
      int k;
      force_pos <= 32'sd0;
      wr(`REG_IRQ_STAT, 32'h7);
      wr(`REG_MAXSPD, 32'hA000);
      wr(`REG_ACCEL, 32'hF00000);
      wr(`REG_TARGET, 32'd100);
      wr(`REG_CMD, 32'h33);
      rd(`REG_STATUS, 32'h3);
      rd(`REG_IRQ_STAT, 32'h0);
      k = 0;
      q = 32'h0;
      while (q[2] !== 1'b1 && k < 30)
      begin
         tick();
         bus(`REG_STATUS, 1'b0, 4'hF, 32'h0, q);
         k++;
      end
      chk(q, 32'h5);
      rd(`REG_IRQ_STAT, 32'h2);
      tick();
      rd(`REG_ERR, 32'hFFFFFF9C);
      wr(`REG_TARGET, 32'd5000);
      wr(`REG_CMD, 32'h2);
      rd(`REG_STATUS, 32'h3);
      tick();
      wr(`REG_CMD, 32'h4);
      rd(`REG_STATUS, 32'h5);
      $display("move and stop test done");
   endtask
   task automatic t_filter();
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      chk({16'h0, drive_o}, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      wr(`REG_FILTER, 32'h5);
      rd(`REG_FILTER, 32'h5);
      wr(`REG_CMD, 32'h1);
      wr(`REG_FILTER, 32'h0);
      rd(`REG_FILTER, 32'h5);
      force_pos <= 32'sd10;
      tick();
      tick();
      chk({16'h0, drive_o}, 32'h0);
      rd(`REG_ERR, 32'hA);
      $display("filter select test done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt <= 0;
      else
         cnt <= cnt + 1;
      if (cnt == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   initial
   begin
      rst_n_i = 1'b0;
      {cyc, stb, we, follow} = 4'h0;
      sel = 4'h0;
      adr = 8'h0;
      wdat = 32'h0;
      force_pos = 32'sh0;
      bad_count = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_not_ready();
      t_pid();
      t_sat();
      t_modes();
      t_ramp();
      t_move();
      t_filter();
      report_and_stop();
   end
endmodule // servo_axis_pid_profile_tb
`default_nettype wire
